// ==== logic/fsr_status_responder.sv ====
// Overview of operation
// - Activity lamps show link speed, flash traffic
// - Module lamp dark without IP; startup alternates
// - Module lamp shows ready, not-ready, error severity
// - Network lamp startup like module; off without IP unless ipConflict/addrService; link green
// - Network lamp bursts three, four, five flashes
// - Async error moves drive to state 7/9
// - Async error stores number, sets status bit
// - Positive reply echoes request function code
// - Negative reply ORs 80h into function code, carries exception code
// - Malformed unit closes connection, no reply
// - Codes 01, 02, 03 for function/address/value
// - Code 04 when processing failed
// - Code 05 acknowledges lengthy requests
// - Code 06 when busy; client model only counts it, no resend
// - Codes 0A and 0B for gateway errors
`timescale 1ns/10ps
module fsr_status_responder #(
	parameter int HalfCycles = fsr_pkg::BlinkHalfCycles
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Port link state, from pins
	input wire logic [1:0] linkUp,
	input wire logic [1:0] linkFast,
	input wire logic [1:0] linkTraffic,
	// Module condition
	input wire logic ipSet,
	input wire logic startup,
	input wire logic ready,
	input wire logic errRecoverable,
	input wire logic errFatal,
	input wire logic ipConflict,
	input wire logic addrService,
	// Lamps
	output fsr_pkg::fsr_lamp_e actLampA,
	output fsr_pkg::fsr_lamp_e actLampB,
	output fsr_pkg::fsr_lamp_e moduleLamp,
	output fsr_pkg::fsr_lamp_e networkLamp,
	// Asynchronous error
	input wire logic asyncErr,
	input wire logic asyncErrQuickStop,
	input wire logic [15:0] asyncErrNumber,
	output logic [15:0] last_error_number,
	output logic errStatusBit,
	output logic [3:0] driveStateReq,
	output logic driveStateReqValid,
	// Request outcome and reply
	input wire logic reqValid,
	input wire logic [7:0] reqFunc,
	input wire fsr_pkg::fsr_outcome_e reqOutcome,
	output logic replyValid,
	output logic [7:0] replyFunc,
	output logic [7:0] replyExc,
	output logic replyHasExc,
	output logic closeConn
);
	fsr_blink_if blink ();

	fsr_blink_timer #(.HalfCycles(HalfCycles)) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.blink(blink.source)
	);

	// Pin synchronisers
	logic [5:0] pinMeta_reg, pinSync_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pinMeta_reg <= 6'h00;
			pinSync_reg <= 6'h00;
		end
		else
		begin
			pinMeta_reg <= {linkTraffic, linkFast, linkUp};
			pinSync_reg <= pinMeta_reg;
		end
	end

	function automatic fsr_pkg::fsr_lamp_e actColour(input logic up,
		input logic fast, input logic busy, input logic ph);
		fsr_pkg::fsr_lamp_e c;
		c = fast ? fsr_pkg::LampGreen : fsr_pkg::LampYellow;
		if (!up)
			actColour = fsr_pkg::LampOff;
		else if (busy && ph)
			actColour = fsr_pkg::LampOff;
		else
			actColour = c;
	endfunction : actColour

	// Burst sequencer
	logic [3:0] burstPos_reg, burstPos_next;
	logic [3:0] burstLen;
	logic burstOn;
	always_comb
	begin
		if (ipConflict)
			burstLen = 4'(fsr_pkg::BurstConflict);
		else if (addrService)
			burstLen = 4'(fsr_pkg::BurstAddrSvc);
		else
			burstLen = 4'(fsr_pkg::BurstNoLink);
		burstPos_next = burstPos_reg;
		if (blink.halfTick)
		begin
			if (burstPos_reg >= 4'(2 * burstLen + fsr_pkg::BurstPauseHalves - 1))
				burstPos_next = 4'h0;
			else
				burstPos_next = burstPos_reg + 4'h1;
		end
	end
	assign burstOn = (burstPos_reg < 4'(2 * burstLen)) && !burstPos_reg[0];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			burstPos_reg <= 4'h0;
		else
			burstPos_reg <= burstPos_next;
	end

	// Lamp logic
	fsr_pkg::fsr_lamp_e act_next [2];
	fsr_pkg::fsr_lamp_e mod_next, net_next;
	fsr_pkg::fsr_lamp_e mix;
	logic anyLink;
	always_comb
	begin
		anyLink = |pinSync_reg[1:0];
		mix = blink.phase ? fsr_pkg::LampRed : fsr_pkg::LampGreen;
		for (int i = 0; i < 2; i++)
			act_next[i] = actColour(pinSync_reg[i], pinSync_reg[2 + i],
				pinSync_reg[4 + i], blink.phase);
		if (startup)
			mod_next = mix;
		else if (!ipSet)
			mod_next = fsr_pkg::LampOff;
		else if (errFatal)
			mod_next = fsr_pkg::LampRed;
		else if (errRecoverable)
			mod_next = blink.phase ? fsr_pkg::LampOff : fsr_pkg::LampRed;
		else if (ready)
			mod_next = fsr_pkg::LampGreen;
		else
			mod_next = blink.phase ? fsr_pkg::LampOff : fsr_pkg::LampGreen;
		if (startup)
			net_next = mix;
		else if (ipConflict || addrService)
			net_next = burstOn ? fsr_pkg::LampGreen : fsr_pkg::LampOff;
		else if (!ipSet)
			net_next = fsr_pkg::LampOff;
		else if (anyLink)
			net_next = fsr_pkg::LampGreen;
		else
			net_next = burstOn ? fsr_pkg::LampGreen : fsr_pkg::LampOff;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			actLampA <= fsr_pkg::LampOff;
			actLampB <= fsr_pkg::LampOff;
			moduleLamp <= fsr_pkg::LampOff;
			networkLamp <= fsr_pkg::LampOff;
		end
		else
		begin
			actLampA <= act_next[0];
			actLampB <= act_next[1];
			moduleLamp <= mod_next;
			networkLamp <= net_next;
		end
	end

	// Asynchronous error capture
	logic [15:0] lastErr_next;
	logic errBit_next;
	logic [3:0] state_next;
	always_comb
	begin
		lastErr_next = last_error_number;
		errBit_next = errStatusBit;
		state_next = driveStateReq;
		if (asyncErr)
		begin
			lastErr_next = asyncErrNumber;
			errBit_next = 1'b1;
			state_next = asyncErrQuickStop ? fsr_pkg::StateQuickStop
				: fsr_pkg::StateFault;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			last_error_number <= fsr_pkg::LastErrorReset;
			errStatusBit <= 1'b0;
			driveStateReq <= 4'h0;
			driveStateReqValid <= 1'b0;
		end
		else
		begin
			last_error_number <= lastErr_next;
			errStatusBit <= errBit_next;
			driveStateReq <= state_next;
			driveStateReqValid <= asyncErr;
		end
	end

	// Reply former
	logic rv_next, cc_next, he_next;
	logic [7:0] rf_next, re_next;
	always_comb
	begin
		rv_next = 1'b0;
		cc_next = 1'b0;
		he_next = 1'b0;
		rf_next = replyFunc;
		re_next = 8'h00;
		if (reqValid)
		begin
			rv_next = 1'b1;
			he_next = 1'b1;
			rf_next = reqFunc | fsr_pkg::ErrFlag;
			case (reqOutcome)
				fsr_pkg::OutOk:
				begin
					he_next = 1'b0;
					rf_next = reqFunc;
				end
				fsr_pkg::OutMalformed:
				begin
					rv_next = 1'b0;
					he_next = 1'b0;
					cc_next = 1'b1;
				end
				fsr_pkg::OutBadFunc: re_next = fsr_pkg::ExIllegalFunc;
				fsr_pkg::OutBadAddr: re_next = fsr_pkg::ExIllegalAddr;
				fsr_pkg::OutBadValue: re_next = fsr_pkg::ExIllegalValue;
				fsr_pkg::OutFail: re_next = fsr_pkg::ExServerFail;
				fsr_pkg::OutLong: re_next = fsr_pkg::ExAck;
				fsr_pkg::OutBusy: re_next = fsr_pkg::ExBusy;
				fsr_pkg::OutGwPath: re_next = fsr_pkg::ExGwPath;
				fsr_pkg::OutGwTarget: re_next = fsr_pkg::ExGwTarget;
				default: re_next = fsr_pkg::ExServerFail;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			replyValid <= 1'b0;
			closeConn <= 1'b0;
			replyHasExc <= 1'b0;
			replyFunc <= 8'h00;
			replyExc <= 8'h00;
		end
		else
		begin
			replyValid <= rv_next;
			closeConn <= cc_next;
			replyHasExc <= he_next;
			replyFunc <= rf_next;
			replyExc <= re_next;
		end
	end

	// Checks
	a_pos_reply_func: assert property (@(posedge clk) disable iff (!rst_n)
		reqValid && reqOutcome == fsr_pkg::OutOk |=> replyValid
		&& !replyHasExc && replyFunc == $past(reqFunc))
		else $error("Positive reply function code wrong");
	a_neg_reply_func: assert property (@(posedge clk) disable iff (!rst_n)
		replyValid && replyHasExc |-> replyFunc[7] && replyExc != 8'h00)
		else $error("Negative reply lacks flag or code");
	a_malformed_close: assert property (@(posedge clk) disable iff (!rst_n)
		reqValid && reqOutcome == fsr_pkg::OutMalformed
		|=> closeConn && !replyValid)
		else $error("Malformed request not closed");
	a_busy_code: assert property (@(posedge clk) disable iff (!rst_n)
		reqValid && reqOutcome == fsr_pkg::OutBusy
		|=> replyExc == fsr_pkg::ExBusy)
		else $error("Busy code wrong");
	a_err_store: assert property (@(posedge clk) disable iff (!rst_n)
		asyncErr |=> last_error_number == $past(asyncErrNumber) && errStatusBit)
		else $error("Error number not stored");
	a_err_state: assert property (@(posedge clk) disable iff (!rst_n)
		asyncErr |=> driveStateReqValid && driveStateReq ==
		($past(asyncErrQuickStop) ? fsr_pkg::StateQuickStop : fsr_pkg::StateFault))
		else $error("Drive state not requested");
	a_mod_dark: assert property (@(posedge clk) disable iff (!rst_n)
		!ipSet && !startup ##1 !ipSet && !startup |-> moduleLamp == fsr_pkg::LampOff)
		else $error("Module lamp not dark");
	a_net_green: assert property (@(posedge clk) disable iff (!rst_n)
		(ipSet && !startup && !ipConflict && !addrService
		&& pinSync_reg[1:0] != 2'b00) |=> networkLamp == fsr_pkg::LampGreen)
		else $error("Network lamp not green");
endmodule : fsr_status_responder

// ==== logic/fsr_pkg.sv ====
package fsr_pkg;
	// Clock and blink timing
	localparam int ClkHz = 25_000_000;
	localparam int BlinkHalfMs = 200;
	localparam int BlinkHalfCycles = ClkHz / 1000 * BlinkHalfMs;
	localparam int BurstPauseHalves = 6;
	localparam int BurstNoLink = 3;
	localparam int BurstConflict = 4;
	localparam int BurstAddrSvc = 5;
	// Function code marker of a negative reply
	localparam logic [7:0] ErrFlag = 8'h80;
	// Exception codes
	localparam logic [7:0] ExIllegalFunc = 8'h01;
	localparam logic [7:0] ExIllegalAddr = 8'h02;
	localparam logic [7:0] ExIllegalValue = 8'h03;
	localparam logic [7:0] ExServerFail = 8'h04;
	localparam logic [7:0] ExAck = 8'h05;
	localparam logic [7:0] ExBusy = 8'h06;
	localparam logic [7:0] ExGwPath = 8'h0A;
	localparam logic [7:0] ExGwTarget = 8'h0B;
	// Drive operating states entered on error
	localparam logic [3:0] StateQuickStop = 4'h7;
	localparam logic [3:0] StateFault = 4'h9;
	// Error bit in status words
	localparam int ErrBit = 15;
	localparam logic [15:0] LastErrorReset = 16'h0000;
	// Lamp colour codes
	typedef enum logic [1:0] {LampOff, LampGreen, LampRed, LampYellow} fsr_lamp_e;
	// Request outcome supplied by the protocol engine
	typedef enum logic [3:0] {
		OutOk, OutMalformed, OutBadFunc, OutBadAddr, OutBadValue,
		OutFail, OutLong, OutBusy, OutGwPath, OutGwTarget
	} fsr_outcome_e;
endpackage : fsr_pkg

// ==== logic/fsr_blink_if.sv ====
`timescale 1ns/10ps
interface fsr_blink_if;
	logic phase;
	logic halfTick;
	modport source (output phase, output halfTick);
	modport sink (input phase, input halfTick);
endinterface : fsr_blink_if

// ==== logic/fsr_blink_timer.sv ====
`timescale 1ns/10ps
module fsr_blink_timer #(
	parameter int HalfCycles = fsr_pkg::BlinkHalfCycles
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Blink timing
	fsr_blink_if.source blink
);
	logic [22:0] cnt_reg, cnt_next;
	logic phase_reg, phase_next;
	logic wrap;

	assign wrap = (cnt_reg == 23'(HalfCycles - 1));

	always_comb
	begin
		cnt_next = wrap ? 23'h00_0000 : cnt_reg + 23'h00_0001;
		phase_next = wrap ? ~phase_reg : phase_reg;
	end

	// Fixed-period blink base
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 23'h00_0000;
			phase_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			phase_reg <= phase_next;
		end
	end

	assign blink.phase = phase_reg;
	assign blink.halfTick = wrap;
endmodule : fsr_blink_timer

// ==== testbench/fsr_client_model.sv ====
`timescale 1ns/10ps
module fsr_client_model (
	// Clock
	input wire logic clk,
	// Request side
	output logic reqValid,
	output logic [7:0] reqFunc,
	output fsr_pkg::fsr_outcome_e reqOutcome,
	// Reply side
	input wire logic replyValid,
	input wire logic replyHasExc,
	input wire logic [7:0] replyExc
);
	int busyCount = 0;
	initial
	begin
		reqValid = 1'b0;
		reqFunc = 8'h00;
		reqOutcome = fsr_pkg::OutOk;
	end
	// One request pulse, then release
	task automatic send(input logic [7:0] f, input fsr_pkg::fsr_outcome_e o);
		@(posedge clk);
		reqValid <= 1'b1;
		reqFunc <= f;
		reqOutcome <= o;
		@(posedge clk);
		reqValid <= 1'b0;
		reqFunc <= ~f;
	endtask : send
	// Busy replies only counted; resend left to the caller
	always @(posedge clk)
		if (replyValid && replyHasExc && replyExc == fsr_pkg::ExBusy)
			busyCount <= busyCount + 1;
endmodule : fsr_client_model

// ==== testbench/test_fieldbus_status_and_exception_responder.sv ====
`timescale 1ns/10ps
module test_fieldbus_status_and_exception_responder;
	localparam int Half = 4;
	`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
		num_errors++; $display("ERROR %0t mismatch", $time); end end
	logic clk = 1'b0, rst_n = 1'b0;
	logic [1:0] linkUp = 2'b00, linkFast = 2'b00, linkTraffic = 2'b00;
	logic ipSet = 1'b0, startup = 1'b0, ready = 1'b0, errRecoverable = 1'b0;
	logic errFatal = 1'b0, ipConflict = 1'b0, addrService = 1'b0;
	logic asyncErr = 1'b0, asyncErrQuickStop = 1'b0;
	logic [15:0] asyncErrNumber = 16'h0000, lastErr;
	fsr_pkg::fsr_lamp_e lampA, lampB, lampM, lampN, cur, prev;
	logic errBit, stReqValid, reqValid, replyValid, replyHasExc, closeConn;
	logic [3:0] stReq;
	logic [7:0] reqFunc, replyFunc, replyExc, f, ex;
	fsr_pkg::fsr_outcome_e reqOutcome;
	int num_errors = 0, cmp_count = 0, seed = 32'ha7f1, cyc = 0;
	int gN, rN, oN, yN, riseN;
	always #20 clk = ~clk;
	fsr_status_responder #(.HalfCycles(Half)) uut (.clk(clk), .rst_n(rst_n),
		.linkUp(linkUp), .linkFast(linkFast), .linkTraffic(linkTraffic),
		.ipSet(ipSet), .startup(startup), .ready(ready),
		.errRecoverable(errRecoverable), .errFatal(errFatal),
		.ipConflict(ipConflict), .addrService(addrService),
		.actLampA(lampA), .actLampB(lampB), .moduleLamp(lampM),
		.networkLamp(lampN), .asyncErr(asyncErr),
		.asyncErrQuickStop(asyncErrQuickStop),
		.asyncErrNumber(asyncErrNumber), .last_error_number(lastErr),
		.errStatusBit(errBit), .driveStateReq(stReq),
		.driveStateReqValid(stReqValid), .reqValid(reqValid),
		.reqFunc(reqFunc), .reqOutcome(reqOutcome), .replyValid(replyValid),
		.replyFunc(replyFunc), .replyExc(replyExc),
		.replyHasExc(replyHasExc), .closeConn(closeConn));
	fsr_client_model client (.clk(clk), .reqValid(reqValid),
		.reqFunc(reqFunc), .reqOutcome(reqOutcome), .replyValid(replyValid),
		.replyHasExc(replyHasExc), .replyExc(replyExc));
	function automatic logic [7:0] excOf(input int o);
		logic [7:0] t[10] = '{8'h00, 8'h00, fsr_pkg::ExIllegalFunc,
			fsr_pkg::ExIllegalAddr, fsr_pkg::ExIllegalValue,
			fsr_pkg::ExServerFail, fsr_pkg::ExAck, fsr_pkg::ExBusy,
			fsr_pkg::ExGwPath, fsr_pkg::ExGwTarget};
		return t[o];
	endfunction : excOf
	function automatic fsr_pkg::fsr_lamp_e lampOf(input int s);
		return s == 0 ? lampA : s == 1 ? lampB : s == 2 ? lampM : lampN;
	endfunction : lampOf
	// Colour census of one lamp over n cycles
	task automatic watch(input int s, input int n);
		gN = 0; rN = 0; oN = 0; yN = 0; riseN = 0;
		repeat (8) @(posedge clk);
		#1 prev = lampOf(s);
		repeat (n)
		begin
			@(posedge clk);
			#1 cur = lampOf(s);
			gN += cur == fsr_pkg::LampGreen;
			rN += cur == fsr_pkg::LampRed;
			oN += cur == fsr_pkg::LampOff;
			yN += cur == fsr_pkg::LampYellow;
			riseN += cur == fsr_pkg::LampGreen && prev != fsr_pkg::LampGreen;
			prev = cur;
		end
	endtask : watch
	task automatic test_done;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			test_done();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		watch(2, 8);
		`CHK(oN, 8)
		for (int i = 0; i < 24; i++)
		begin
			f = i < 4 ? 8'h7f : 8'($unsigned($random(seed)) % 127 + 1);
			ex = excOf(i % 10);
			client.send(f, fsr_pkg::fsr_outcome_e'(i % 10));
			#1;
			`CHK(closeConn, i % 10 == 1)
			`CHK(replyValid, i % 10 != 1)
			if (i % 10 == 0)
			begin
				`CHK({replyFunc, replyHasExc}, {f, 1'b0})
			end
			else if (i % 10 != 1)
			begin
				`CHK({replyFunc, replyExc, replyHasExc}, {f + 8'h80, ex, 1'b1})
			end
		end
		`CHK(client.busyCount, 2)
		$display("reply test done");
		repeat (4)
		begin
			@(posedge clk);
			asyncErr <= 1'b1;
			asyncErrQuickStop <= 1'($random(seed));
			asyncErrNumber <= 16'($random(seed));
			@(posedge clk);
			asyncErr <= 1'b0;
			#1;
			`CHK({lastErr, errBit, stReqValid}, {asyncErrNumber, 2'b11})
			`CHK(stReq, asyncErrQuickStop ? 4'h7 : 4'h9)
		end
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK({lastErr, errBit, stReqValid}, {fsr_pkg::LastErrorReset, 2'b00})
		$display("error test done");
		@(posedge clk);
		{linkUp, linkFast, linkTraffic} <= 6'b01_01_00;
		watch(0, 16);
		`CHK(gN, 16)
		watch(1, 16);
		`CHK(oN, 16)
		@(posedge clk);
		{linkFast, linkTraffic} <= 4'b00_01;
		watch(0, 32);
		`CHK({yN > 0, oN > 0, gN}, {2'b11, 32'd0})
		@(posedge clk);
		{ipSet, startup} <= 2'b11;
		watch(2, 32);
		`CHK({gN > 0, rN > 0}, 2'b11)
		watch(3, 32);
		`CHK({gN > 0, rN > 0}, 2'b11)
		@(posedge clk);
		{startup, ready} <= 2'b01;
		watch(2, 16);
		`CHK(gN, 16)
		watch(3, 16);
		`CHK(gN, 16)
		@(posedge clk);
		ready <= 1'b0;
		watch(2, 32);
		`CHK({gN > 0, oN > 0, rN}, {2'b11, 32'd0})
		@(posedge clk);
		errRecoverable <= 1'b1;
		watch(2, 32);
		`CHK({rN > 0, oN > 0, gN}, {2'b11, 32'd0})
		@(posedge clk);
		errFatal <= 1'b1;
		watch(2, 16);
		`CHK(rN, 16)
		@(posedge clk);
		{errFatal, errRecoverable, linkUp} <= 4'b0000;
		watch(3, (2 * 3 + 6) * Half);
		`CHK({riseN, rN}, {32'd3, 32'd0})
		@(posedge clk);
		ipConflict <= 1'b1;
		watch(3, (2 * 4 + 6) * Half);
		`CHK(riseN, 4)
		@(posedge clk);
		{ipConflict, addrService} <= 2'b01;
		watch(3, (2 * 5 + 6) * Half);
		`CHK(riseN, 5)
		@(posedge clk);
		{addrService, ipSet} <= 2'b00;
		watch(3, 16);
		`CHK(oN, 16)
		$display("lamp test done");
		test_done();
	end
endmodule : test_fieldbus_status_and_exception_responder
